// ==== verilog/hrss_pkg.sv ====
/*
 * Constants for the reset-time strap sampler: register offsets, field
 * positions, reset values and the fixed management-bus address prefix.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package hrss_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] HRSS_OFF_STRAP  = 8'h00;
    localparam logic [7:0] HRSS_OFF_CTRL   = 8'h04;
    localparam logic [7:0] HRSS_OFF_ADDR   = 8'h08;
    // Strap register fields
    localparam int HRSS_B_PWR   = 0;
    localparam int HRSS_B_GANG  = 1;
    localparam int HRSS_B_LED   = 2;
    localparam int HRSS_B_MBUS  = 3;
    localparam int HRSS_B_FPM   = 4;
    localparam int HRSS_B_PIND  = 5;
    localparam int HRSS_B_USB3  = 6;
    // Control register fields
    localparam int HRSS_B_PWREN = 0;
    localparam int HRSS_B_SS    = 1;
    localparam logic [1:0] HRSS_CTRL_RST = 2'h0;
    // ****************************************************************
    // Management-bus address
    // ****************************************************************
    localparam logic [3:0] HRSS_ADDR_PREFIX = 4'h8;
    // AXI responses
    localparam logic [1:0] HRSS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] HRSS_RESP_SLVERR = 2'h2;
endpackage

// ==== verilog/hrss_capture.sv ====
/*
 * Strap capture: takes the three strap pins and the mode select in the
 * first cycle after reset release and then holds them until next reset.
 * Assumes straps are stable and synchronous to aclk around release.
 */
`timescale 1ns/100ps
module hrss_capture
    import hrss_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Strap pins
    input  wire logic [3:0] strap_in,
    // Captured values
    output logic      [3:0] strap_q,
    output logic            captured
);
    // Reset values are constants; the pins are caught only after release
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            captured <= 1'b0;
            strap_q  <= 4'hF;
        end
        else if (!captured)
        begin
            captured <= 1'b1;
            strap_q  <= strap_in;
        end
    end

    AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        captured |=> strap_q == $past(strap_q))
        else $error("strap value changed after capture");
endmodule

// ==== verilog/hrss_top.sv ====
/*
 * Reset-time strap sampler with upstream-link status, reachable over
 * AXI4-Lite. Assumes one 50 MHz clock and a synchronous active-low reset.
 * Straps captured at release; power enable and link speed from software.
 */
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
// Functional notes
// - USB3 status output follows upstream link mode
// - Sample power-management strap at reset release
// - Low strap means full power management
// - Drive port power enable when supported (code also needs ctrl bit PWREN set)
// - Bus mode: power strap is address bit1
// - Fixed ones at bits 2,3 superseded
// - Sample ganged strap at release, low=LEDs
// - Sample port-indicator strap, low enables LEDs
// - Duplicate bit3 resolved by address format
// - Address is 1000 p g x rw
module hrss_top
    import hrss_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Strap pins
    input  wire logic        power_mgmt_strap_addr1,
    input  wire logic        gang_strap_addr_pin,
    input  wire logic        port_led_strap_addr_pin,
    input  wire logic        mgmt_bus_mode_select,
    // Status, power and management-bus address outputs
    output logic             usb3_status_out,
    output logic             port0_power_enable_out,
    output logic [6:0]       mgmt_bus_addr
);
    logic [3:0] strap_q;
    logic       captured;
    logic [1:0] ctrl;
    logic       full_pm;
    logic       pind_en;
    logic       led_en;
    logic       mbus_mode;

    hrss_capture u_cap
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .strap_in ({mgmt_bus_mode_select, port_led_strap_addr_pin,
                    gang_strap_addr_pin, power_mgmt_strap_addr1}),
        .strap_q  (strap_q),
        .captured (captured)
    );

    // ****************************************************************
    // Strap decode
    // ****************************************************************
    assign full_pm   = !strap_q[0];
    assign led_en    = !strap_q[1];
    assign pind_en   = !strap_q[2];
    assign mbus_mode = !strap_q[3];

    // Address bits follow the strap pins, so the fixed-one claim is dropped
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mgmt_bus_addr <= 7'h00;
        else if (mbus_mode && captured)
            mgmt_bus_addr <= {HRSS_ADDR_PREFIX, strap_q[2], strap_q[1], strap_q[0]};
        else
            mgmt_bus_addr <= 7'h00;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            usb3_status_out        <= 1'b0;
            port0_power_enable_out <= 1'b0;
        end
        else
        begin
            usb3_status_out        <= ctrl[HRSS_B_SS];
            port0_power_enable_out <= full_pm && captured && ctrl[HRSS_B_PWREN];
        end
    end

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Ready only while the slot is empty and no response is pending
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= HRSS_RESP_OKAY;
            ctrl    <= HRSS_CTRL_RST;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_hold && w_hold)
            begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr[7:2] == HRSS_OFF_CTRL[7:2])
                begin
                    s_axi_bresp <= HRSS_RESP_OKAY;
                    if (w_strb[0])
                        ctrl <= w_data[1:0];
                end
                else if (aw_addr[7:2] == HRSS_OFF_STRAP[7:2] || aw_addr[7:2] == HRSS_OFF_ADDR[7:2])
                    s_axi_bresp <= HRSS_RESP_OKAY;
                else
                    s_axi_bresp <= HRSS_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= HRSS_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= HRSS_RESP_OKAY;
            case (s_axi_araddr[7:2])
                HRSS_OFF_STRAP[7:2]:
                    s_axi_rdata <= {25'h0, usb3_status_out, pind_en, full_pm,
                                    strap_q[3], strap_q[2], strap_q[1], strap_q[0]};
                HRSS_OFF_CTRL[7:2]:
                    s_axi_rdata <= {30'h0, ctrl};
                HRSS_OFF_ADDR[7:2]:
                    s_axi_rdata <= {25'h0, mgmt_bus_addr};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= HRSS_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_USB3: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 usb3_status_out == $past(ctrl[HRSS_B_SS]))
        else $error("usb3 status does not follow link mode");
    AST_PWR_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        strap_q[0] && captured |=> !port0_power_enable_out)
        else $error("power enable driven without power management");
    AST_PWR_ON: assert property (@(posedge aclk) disable iff (!aresetn)
        !strap_q[0] && captured && ctrl[HRSS_B_PWREN] |=> port0_power_enable_out)
        else $error("power enable not driven");
    AST_ADDR1: assert property (@(posedge aclk) disable iff (!aresetn)
        captured && mbus_mode |=> mgmt_bus_addr[0] == $past(strap_q[0]))
        else $error("address bit 1 wrong");
    AST_ADDR_PRE: assert property (@(posedge aclk) disable iff (!aresetn)
        captured && mbus_mode |=> mgmt_bus_addr[6:3] == HRSS_ADDR_PREFIX)
        else $error("address prefix wrong");
    AST_ADDR_P: assert property (@(posedge aclk) disable iff (!aresetn)
        captured && mbus_mode |=> mgmt_bus_addr[2:1] == $past(strap_q[2:1]))
        else $error("address strap bits wrong");
    AST_LED: assert property (@(posedge aclk) disable iff (!aresetn)
        !captured ##1 captured |-> led_en == !$past(gang_strap_addr_pin)
        && pind_en == !$past(port_led_strap_addr_pin))
        else $error("led decode wrong");
    AST_CAP: assert property (@(posedge aclk)
        !aresetn ##1 aresetn |=> captured && strap_q[0] == $past(power_mgmt_strap_addr1))
        else $error("strap not sampled at release");
endmodule

// ==== sim/hrss_strap_board.sv ====
/*
 * Board model of the strap resistors feeding the sampler's strap pins.
 * Assumes the strap pins have on-chip pull-ups, so an unfitted strap reads high.
 */
`timescale 1ns/100ps
module hrss_strap_board
(
    // Fitted mask and driven level, bit0 power, bit1 gang, bit2 led, bit3 mode
    input  wire logic [3:0] fit,
    input  wire logic [3:0] lvl,
    // Strap pins
    output logic      [3:0] pin
);
    // Unfitted strap floats and the pull-up wins
    assign pin = lvl | ~fit;
endmodule

// ==== sim/hub_reset_strap_sampler_tb.sv ====
/*
 * Self-checking bench for the strap sampler, driving it over AXI4-Lite.
 * Assumes a 50 MHz clock and the board strap model beside the block.
 */
`timescale 1ns/100ps
module hub_reset_strap_sampler_tb;
    import hrss_pkg::*;
    logic        aclk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  awa  = 8'h00;
    logic [7:0]  ara  = 8'h00;
    logic [31:0] wd   = 32'h0;
    logic        awv  = 1'b0;
    logic        wv   = 1'b0;
    logic        bre  = 1'b0;
    logic        arv  = 1'b0;
    logic        rre  = 1'b0;
    logic [3:0]  fit  = 4'hF;
    logic [3:0]  lvl  = 4'hF;
    logic [3:0]  ws   = 4'hF;
    logic [1:0]  resp;
    logic [31:0] dat;
    wire         awr, wr, bv, arr, rv, usb3, pwren;
    wire  [1:0]  br, rr;
    wire  [31:0] rd;
    wire  [6:0]  ma;
    wire  [3:0]  pin;
    int          n_mismatch = 0;
    int          n_tests    = 0;
    int          cyc        = 0;

    always #10 aclk = ~aclk;

    hrss_strap_board i_board (.fit(fit), .lvl(lvl), .pin(pin));

    hrss_top i_dut (.aclk(aclk), .aresetn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .power_mgmt_strap_addr1(pin[0]), .gang_strap_addr_pin(pin[1]),
        .port_led_strap_addr_pin(pin[2]), .mgmt_bus_mode_select(pin[3]),
        .usb3_status_out(usb3), .port0_power_enable_out(pwren), .mgmt_bus_addr(ma));

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, s, e);
        end
    endtask

    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    task wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        resp = br;
        bre <= 1'b0;
    endtask

    task rd32(input logic [7:0] a);
        @(posedge aclk);
        ara <= a; arv <= 1'b1; rre <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        resp = rr;
        dat  = rd;
        rre <= 1'b0;
    endtask

    task do_reset;
        rstn <= 1'b0;
        repeat (8) @(posedge aclk);
        rstn <= 1'b1;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task test_straps(input logic [3:0] f, input logic [3:0] v);
        logic [3:0] e;
        logic [6:0] ea;
        e  = v | ~f;
        ea = e[3] ? 7'h00 : {HRSS_ADDR_PREFIX, e[2], e[1], e[0]};
        fit <= f;
        lvl <= v;
        do_reset;
        repeat (3) @(posedge aclk);
        // Straps move after capture and must be ignored
        lvl <= ~v;
        repeat (2) @(posedge aclk);
        chk(ma, ea);
        chk(usb3, 0);
        chk(pwren, 0);
        wr32(HRSS_OFF_CTRL, 32'h3);
        repeat (2) @(posedge aclk);
        chk(usb3, 1);
        chk(pwren, !e[0]);
        rd32(HRSS_OFF_STRAP);
        chk(dat, {25'h0, 1'b1, ~e[2], ~e[0], e});
        rd32(HRSS_OFF_ADDR);
        chk(dat, {25'h0, ea});
        wr32(HRSS_OFF_CTRL, 32'h0);
        repeat (2) @(posedge aclk);
        chk(usb3, 0);
        chk(pwren, 0);
        $display("strap test %h done", e);
    endtask

    task test_bus;
        wr32(HRSS_OFF_STRAP, 32'hFF);
        chk(resp, HRSS_RESP_OKAY);
        wr32(8'h0C, 32'h1);
        chk(resp, HRSS_RESP_SLVERR);
        rd32(8'h0C);
        chk(resp, HRSS_RESP_SLVERR);
        chk(dat, 32'h0);
        wr32(HRSS_OFF_CTRL, 32'h2);
        rd32(HRSS_OFF_CTRL);
        chk(resp, HRSS_RESP_OKAY);
        chk(dat, 32'h2);
        // Low byte strobe off: control bits must stay as they are
        ws <= 4'hE;
        wr32(HRSS_OFF_CTRL, 32'h1);
        ws <= 4'hF;
        rd32(HRSS_OFF_CTRL);
        chk(dat, 32'h2);
        // Strap write earlier must not have touched the captured straps
        rd32(HRSS_OFF_STRAP);
        chk(dat, 32'h0000_004F);
        $display("bus test done");
    endtask

    // Hang guard well above the expected run length
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_mismatch++;
            print_verdict;
        end
    end

    initial
    begin
        test_straps(4'hF, 4'h0);
        test_straps(4'hF, 4'h7);
        test_straps(4'hF, 4'h9);
        test_straps(4'hF, 4'h6);
        test_straps(4'hF, 4'h8);
        test_straps(4'h0, 4'h0);
        test_bus;
        print_verdict;
    end
endmodule
